// [inc/dmm_pkg.sv]
package dmm_pkg;
   localparam logic [7:0]  SP_RESET      = 8'h07;
   localparam logic [7:0]  PSW_RESET     = 8'h00;
   localparam logic [7:0]  PSW_ADDR      = 8'hD0;
   localparam logic [7:0]  SP_ADDR       = 8'h81;
   localparam int          PSW_BANK_LSB  = 3;
   localparam logic [7:0]  UPPER_BASE    = 8'h80;
   localparam logic [7:0]  BIT_BASE      = 8'h20;
   localparam logic [7:0]  UID_BASE      = 8'hFC;
   localparam logic [15:0] PC_RESET      = 16'h0000;
   localparam logic [7:0]  PORT_RESET    = 8'hFF;
   // Identifier value is arbitrary
   localparam logic [31:0] UID_VALUE     = 32'h1234_5678;

   typedef enum logic [3:0] {
      SP_IDLE = 4'b0001,
      SP_PUSH = 4'b0010,
      SP_POP  = 4'b0100,
      SP_WAIT = 4'b1000
   } dmm_stk_t;

   typedef enum logic [2:0] {
      SPC_DIRECT   = 3'h0,
      SPC_INDIRECT = 3'h1,
      SPC_GPREG    = 3'h2,
      SPC_GPIND    = 3'h3,
      SPC_XDATA16  = 3'h4,
      SPC_XDATA8   = 3'h5,
      SPC_BIT      = 3'h6,
      SPC_STACK    = 3'h7
   } dmm_space_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      dmm_space_t space;
      logic       pop;
      logic [15:0] addr;
      logic [7:0] wdata;
   } dmm_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] rdata;
      logic       sfr_sel;
   } dmm_rsp_t;
endpackage

// [logic/dmm_data_map.sv]
`timescale 1ns/100ps
module dmm_data_map (
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             por_rst_i,
   input  wire logic             supply_rst_i,
   input  wire logic             uid_internal_i,
   input  wire logic             flash_write_sel_i,
   input  wire dmm_pkg::dmm_req_t req_i,
   input  wire logic [7:0]       sfr_rdata_i,
   output dmm_pkg::dmm_rsp_t     rsp_o,
   output logic                  sfr_we_o,
   output logic [7:0]            sfr_addr_o,
   output logic [7:0]            sfr_wdata_o,
   output logic                  flash_we_o,
   output logic [15:0]           flash_addr_o,
   output logic [7:0]            flash_wdata_o,
   output logic                  core_halt_o,
   output logic                  irq_timer_en_o,
   output logic [15:0]           program_counter_o,
   output logic                  lp_osc_sel_o,
   output logic                  wdt_lfo_en_o,
   output logic [7:0]            port_latch_o,
   output logic                  port_pullup_en_o,
   output logic                  rst_pin_o,
   output logic                  rst_pin_oe_n_o,
   output logic [7:0]            stack_pointer_o,
   output logic [1:0]            bank_sel_o,
   output logic                  por_flag_o
);
   import dmm_pkg::*;

   // Separate arrays keep upper indirect RAM apart from special function space
   logic [7:0] iram_q [0:255];
   logic [7:0] onchip_external_ram_q [0:255];
   logic [7:0] psw_q, psw_d;
   logic [7:0] sp_q, sp_d;
   logic       por_flag_q, por_flag_d;
   logic       hold_q, hold_d;
   logic       drive_rst_q, drive_rst_d;
   dmm_stk_t   stk_q, stk_d;
   dmm_rsp_t   rsp_q, rsp_d;

   logic       ram_we;
   logic [7:0] ram_addr;
   logic [7:0] ram_wdata;
   logic       x_we;
   logic [7:0] x_addr;
   logic [7:0] ind_ptr;
   logic [7:0] gp_addr;
   logic [7:0] bit_byte;
   logic [2:0] bit_pos;
   logic       sfr_hit;

   assign bank_sel_o = psw_q[PSW_BANK_LSB +: 2];
   // Index register zero or one of the active bank
   assign ind_ptr    = iram_q[{3'h0, bank_sel_o, 2'h0, req_i.addr[0]}];
   assign gp_addr    = {3'h0, bank_sel_o, req_i.addr[2:0]};
   assign bit_byte   = BIT_BASE + {4'h0, req_i.addr[6:3]};
   assign bit_pos    = req_i.addr[2:0];
   assign x_addr     = (req_i.space == SPC_XDATA16) ? req_i.addr[7:0] : ind_ptr;

   always_comb begin
      ram_we    = 1'b0;
      ram_addr  = 8'h00;
      ram_wdata = req_i.wdata;
      x_we      = 1'b0;
      sfr_hit   = 1'b0;
      sfr_we_o  = 1'b0;
      sfr_addr_o  = req_i.addr[7:0];
      sfr_wdata_o = req_i.wdata;
      flash_we_o  = 1'b0;
      flash_addr_o  = req_i.addr;
      flash_wdata_o = req_i.wdata;
      psw_d     = psw_q;
      rsp_d     = '0;
      if (req_i.valid && !sys_rst_i) begin
         rsp_d.valid = 1'b1;
         case (req_i.space)
            SPC_DIRECT: begin
               if (req_i.addr[7]) begin
                  sfr_hit = 1'b1;
               end else begin
                  ram_addr = req_i.addr[7:0];
               end
            end
            SPC_INDIRECT: ram_addr = req_i.addr[7:0];
            SPC_GPREG:    ram_addr = gp_addr;
            SPC_GPIND:    ram_addr = ind_ptr;
            SPC_BIT: begin
               // Bit operation chosen by space code, not address
               if (req_i.addr[7]) begin
                  sfr_hit = 1'b1;
               end else begin
                  ram_addr = bit_byte;
                  ram_wdata = iram_q[bit_byte];
                  ram_wdata[bit_pos] = req_i.wdata[0];
               end
            end
            SPC_STACK:    ram_addr = req_i.pop ? sp_q : sp_q + 8'h01;
            default: begin
               if (flash_write_sel_i && req_i.space == SPC_XDATA16) begin
                  flash_we_o = req_i.write;
               end else begin
                  x_we = req_i.write;
               end
            end
         endcase
         if (sfr_hit) begin
            sfr_we_o = req_i.write && req_i.addr[7:0] != PSW_ADDR && req_i.addr[7:0] != SP_ADDR;
            rsp_d.sfr_sel = 1'b1;
            if (req_i.addr[7:0] == PSW_ADDR) begin
               rsp_d.rdata = psw_q;
               if (req_i.write) psw_d = req_i.wdata;
            end else if (req_i.addr[7:0] == SP_ADDR) begin
               rsp_d.rdata = sp_q;
            end else begin
               rsp_d.rdata = sfr_rdata_i;
            end
         end else if (req_i.space == SPC_XDATA16 || req_i.space == SPC_XDATA8) begin
            if (!uid_internal_i && x_addr >= UID_BASE) begin
               rsp_d.rdata = UID_VALUE[8*(x_addr[1:0]) +: 8];
            end else begin
               rsp_d.rdata = onchip_external_ram_q[x_addr];
            end
         end else begin
            ram_we = req_i.write;
            if (uid_internal_i && ram_addr >= UID_BASE) begin
               rsp_d.rdata = UID_VALUE[8*(ram_addr[1:0]) +: 8];
            end else if (req_i.space == SPC_BIT) begin
               rsp_d.rdata = {7'h00, iram_q[ram_addr][bit_pos]};
            end else begin
               rsp_d.rdata = iram_q[ram_addr];
            end
         end
      end
   end

   // Stack pointer sequencing
   always_comb begin
      stk_d = SP_IDLE;
      sp_d  = sp_q;
      if (req_i.valid && !sys_rst_i && req_i.space == SPC_STACK) begin
         stk_d = req_i.pop ? SP_POP : SP_PUSH;
         sp_d  = req_i.pop ? sp_q - 8'h01 : sp_q + 8'h01;
      end else if (req_i.valid && !sys_rst_i && sfr_hit && req_i.write && req_i.addr[7:0] == SP_ADDR) begin
         stk_d = SP_WAIT;
         sp_d  = req_i.wdata;
      end
   end

   always_comb begin
      hold_d      = 1'b0;
      drive_rst_d = drive_rst_q;
      por_flag_d  = por_flag_q;
      if (por_rst_i) begin
         por_flag_d = 1'b1;
      end
      if (sys_rst_i) begin
         drive_rst_d = por_rst_i | supply_rst_i | drive_rst_q;
         hold_d      = 1'b1;
      end else begin
         drive_rst_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         psw_q  <= PSW_RESET;
         sp_q   <= SP_RESET;
         stk_q  <= SP_IDLE;
         rsp_q  <= '0;
      end else begin
         psw_q  <= psw_d;
         sp_q   <= sp_d;
         stk_q  <= stk_d;
         rsp_q  <= rsp_d;
      end
      // Only power-on sets this flag; nothing clears it
      por_flag_q  <= por_flag_d;
      hold_q      <= hold_d;
      drive_rst_q <= drive_rst_d;
   end

   // RAM arrays have no reset branch so contents survive
   always_ff @(posedge clk_i) begin
      if (ram_we) iram_q[ram_addr] <= ram_wdata;
      if (x_we) onchip_external_ram_q[x_addr] <= req_i.wdata;
   end

   assign rsp_o             = rsp_q;
   assign stack_pointer_o   = sp_q;
   assign por_flag_o        = por_flag_q;
   assign core_halt_o       = sys_rst_i | hold_q;
   assign irq_timer_en_o    = !(sys_rst_i | hold_q);
   assign program_counter_o = PC_RESET;
   assign lp_osc_sel_o      = 1'b1;
   assign wdt_lfo_en_o      = 1'b1;
   assign port_latch_o      = PORT_RESET;
   assign port_pullup_en_o  = 1'b1;
   assign rst_pin_o         = 1'b0;
   assign rst_pin_oe_n_o    = !(drive_rst_q && sys_rst_i);

   property p_sp_reset;
      @(posedge clk_i) sys_rst_i |=> sp_q == SP_RESET;
   endproperty
   a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not 0x07 after reset");

   property p_push;
      @(posedge clk_i) disable iff (sys_rst_i)
         (req_i.valid && req_i.space == SPC_STACK && !req_i.pop) |=> sp_q == $past(sp_q) + 8'h01;
   endproperty
   a_push: assert property (p_push) else $error("push did not increment stack pointer");

   property p_direct_sfr;
      @(posedge clk_i) disable iff (sys_rst_i)
         (req_i.valid && req_i.space == SPC_DIRECT && req_i.addr[7]) |=> rsp_o.sfr_sel;
   endproperty
   a_direct_sfr: assert property (p_direct_sfr) else $error("direct upper access missed sfr");

   property p_indirect_ram;
      @(posedge clk_i) disable iff (sys_rst_i)
         (req_i.valid && req_i.space == SPC_INDIRECT) |=> !rsp_o.sfr_sel && rsp_o.valid;
   endproperty
   a_indirect_ram: assert property (p_indirect_ram) else $error("indirect access went to sfr");

   property p_flash_sel;
      @(posedge clk_i) disable iff (sys_rst_i)
         flash_we_o |-> flash_write_sel_i && req_i.space == SPC_XDATA16;
   endproperty
   a_flash_sel: assert property (p_flash_sel) else $error("flash write without selection");

   property p_halt;
      @(posedge clk_i) sys_rst_i |-> core_halt_o && !irq_timer_en_o;
   endproperty
   a_halt: assert property (p_halt) else $error("core not halted in reset");

   property p_rst_pin;
      @(posedge clk_i) (sys_rst_i && por_rst_i) ##1 sys_rst_i |-> !rst_pin_oe_n_o;
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("reset pin not driven");

   property p_resp_latency;
      @(posedge clk_i) disable iff (sys_rst_i) req_i.valid |=> rsp_o.valid;
   endproperty
   a_resp_latency: assert property (p_resp_latency) else $error("no response one cycle after request");

   property p_pop;
      @(posedge clk_i) disable iff (sys_rst_i)
         (stk_q == SP_POP) |-> sp_q == $past(sp_q) - 8'h01;
   endproperty
   a_pop: assert property (p_pop) else $error("pop did not decrement stack pointer");

   property p_sp_write;
      @(posedge clk_i) disable iff (sys_rst_i)
         (stk_q == SP_WAIT) |-> sp_q == $past(req_i.wdata);
   endproperty
   a_sp_write: assert property (p_sp_write) else $error("stack pointer write not taken");

   property p_push_addr;
      @(posedge clk_i) disable iff (sys_rst_i)
         (req_i.valid && req_i.space == SPC_STACK && !req_i.pop)
         |-> ram_addr == sp_q + 8'h01 && ram_we == req_i.write;
   endproperty
   a_push_addr: assert property (p_push_addr) else $error("push not aimed one above stack pointer");

   property p_bank_gp;
      @(posedge clk_i) disable iff (sys_rst_i)
         (req_i.valid && req_i.space == SPC_GPREG)
         |-> ram_addr == {3'h0, psw_q[PSW_BANK_LSB +: 2], req_i.addr[2:0]};
   endproperty
   a_bank_gp: assert property (p_bank_gp) else $error("register access outside active bank");

   property p_bit_map;
      @(posedge clk_i) disable iff (sys_rst_i)
         (req_i.valid && req_i.space == SPC_BIT && !req_i.addr[7])
         |-> ram_addr == BIT_BASE + {4'h0, req_i.addr[6:3]};
   endproperty
   a_bit_map: assert property (p_bit_map) else $error("bit address mapped to wrong byte");

   property p_onchip_external_ram_mirror;
      @(posedge clk_i) disable iff (sys_rst_i)
         (req_i.valid && req_i.space == SPC_XDATA16) |-> x_addr == req_i.addr[7:0];
   endproperty
   a_onchip_external_ram_mirror: assert property (p_onchip_external_ram_mirror) else $error("upper external address bits not ignored");

   property p_uid_int;
      @(posedge clk_i) disable iff (sys_rst_i)
         (req_i.valid && uid_internal_i && req_i.space == SPC_INDIRECT && req_i.addr[7:2] == 6'h3F)
         |-> rsp_d.rdata == UID_VALUE[8*req_i.addr[1:0] +: 8];
   endproperty
   a_uid_int: assert property (p_uid_int) else $error("internal identifier byte wrong");

   property p_rst_supply;
      @(posedge clk_i) (sys_rst_i && supply_rst_i) ##1 sys_rst_i |-> !rst_pin_oe_n_o;
   endproperty
   a_rst_supply: assert property (p_rst_supply) else $error("reset pin not driven in supply reset");

   property p_oe_idle;
      @(posedge clk_i) !sys_rst_i |-> rst_pin_oe_n_o;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("reset pin driven outside reset");

   property p_por_flag;
      @(posedge clk_i) por_rst_i |=> por_flag_o;
   endproperty
   a_por_flag: assert property (p_por_flag) else $error("power-on flag not set");
endmodule

// [verif/dmm_sfr_model.sv]
`timescale 1ns/100ps
// Far-side special function space; reads are combinational, as the core expects
module dmm_sfr_model (
   input  wire logic       clk_i,
   input  wire logic       sfr_we_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic [7:0]      sfr_rdata_o
);
   logic [7:0] mem_q [256];
   // Seeded so an untouched register never reads back as a plausible RAM value
   initial begin
      for (int i = 0; i < 256; i++) mem_q[i] = 8'h5A ^ i[7:0];
   end
   assign sfr_rdata_o = mem_q[sfr_addr_i];
   always @(posedge clk_i) begin
      if (sfr_we_i) mem_q[sfr_addr_i] <= sfr_wdata_i;
   end
endmodule

// [verif/test_data_memory_map_and_reset.sv]
`timescale 1ns/100ps
module test_data_memory_map_and_reset;
   import dmm_pkg::*;
   logic        clk_i = 1'b0;
   logic        sys_rst_i, por_rst_i, supply_rst_i;
   logic        uid_i = 1'b0, fsel_i = 1'b0;
   dmm_req_t    req = '0;
   dmm_rsp_t    rsp;
   logic [7:0]  sfr_rdata, sfr_addr, sfr_wdata, rd, port_latch, sp_o, fl_wdata, fw_seen;
   logic [15:0] fl_addr, pc, fa_seen;
   logic [1:0]  bank;
   logic        sfr_we, fl_we, halt, irq_en, lp, wdt, pull, rpin, rpin_oe_n, porf, sfr_seen, fl_seen, sel_seen;
   int          failures = 0, n_tests = 0;

   dmm_data_map dmm_data_map_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_rst_i(por_rst_i),
      .supply_rst_i(supply_rst_i), .uid_internal_i(uid_i), .flash_write_sel_i(fsel_i), .req_i(req),
      .sfr_rdata_i(sfr_rdata), .rsp_o(rsp), .sfr_we_o(sfr_we), .sfr_addr_o(sfr_addr), .sfr_wdata_o(sfr_wdata),
      .flash_we_o(fl_we), .flash_addr_o(fl_addr), .flash_wdata_o(fl_wdata), .core_halt_o(halt),
      .irq_timer_en_o(irq_en),
      .program_counter_o(pc), .lp_osc_sel_o(lp), .wdt_lfo_en_o(wdt), .port_latch_o(port_latch),
      .port_pullup_en_o(pull), .rst_pin_o(rpin), .rst_pin_oe_n_o(rpin_oe_n), .stack_pointer_o(sp_o),
      .bank_sel_o(bank), .por_flag_o(porf));
   dmm_sfr_model dmm_sfr_model_inst (.clk_i(clk_i), .sfr_we_i(sfr_we), .sfr_addr_i(sfr_addr),
      .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata));

   initial begin
      forever #20 clk_i = ~clk_i;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("Checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Valid stays up so calls chain back to back; idle drops it
   task automatic acc(input logic wr, input dmm_space_t s, input logic [15:0] a, input logic [7:0] wd);
      req = '{1'b1, wr, s, ~wr, a, wd};
      #5;
      sfr_seen = sfr_we;
      fl_seen = fl_we;
      fa_seen = fl_addr;
      fw_seen = fl_wdata;
      @(posedge clk_i);
      #1;
      chk("rsp valid", rsp.valid, 1'b1);
      rd = rsp.rdata;
      sel_seen = rsp.sfr_sel;
   endtask

   task automatic idle;
      req.valid = 1'b0;
      @(posedge clk_i);
      #1;
   endtask

   task automatic do_reset(input logic por, input logic sup);
      sys_rst_i = 1'b1;
      por_rst_i = por;
      supply_rst_i = sup;
      repeat (6) @(posedge clk_i);
      #1;
      chk("sp in reset", sp_o, SP_RESET);
      chk("bank in reset", bank, 2'b00);
      chk("halt", halt, 1'b1);
      chk("irq timer en", irq_en, 1'b0);
      chk("port latch", port_latch, PORT_RESET);
      chk("pullup", pull, 1'b1);
      chk("rst pin oe_n", rpin_oe_n, !(por | sup));
      if (por | sup) chk("rst pin", rpin, 1'b0);
      sys_rst_i = 1'b0;
      por_rst_i = 1'b0;
      supply_rst_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      chk("halt after", halt, 1'b0);
      chk("pc", pc, PC_RESET);
      chk("lp osc", lp, 1'b1);
      chk("wdt lfo", wdt, 1'b1);
      chk("por flag", porf, 1'b1);
   endtask

   task automatic t_stack;
      acc(1'b1, SPC_STACK, 16'h0000, 8'h3C);
      chk("sp first push", sp_o, 8'h08);
      acc(1'b1, SPC_STACK, 16'h0000, 8'h4D);
      acc(1'b0, SPC_INDIRECT, 16'h0009, 8'h00);
      chk("push ram", rd, 8'h4D);
      acc(1'b0, SPC_STACK, 16'h0000, 8'h00);
      chk("pop data", rd, 8'h4D);
      chk("sp pop", sp_o, 8'h08);
      acc(1'b0, SPC_INDIRECT, 16'h0008, 8'h00);
      chk("first push ram", rd, 8'h3C);
      acc(1'b1, SPC_DIRECT, {8'h00, SP_ADDR}, 8'hEF);
      acc(1'b1, SPC_STACK, 16'h0000, 8'h5E);
      chk("sp high", sp_o, 8'hF0);
      acc(1'b0, SPC_INDIRECT, 16'h00F0, 8'h00);
      chk("high stack ram", rd, 8'h5E);
      idle();
   endtask

   task automatic t_space;
      acc(1'b1, SPC_DIRECT, 16'h0090, 8'hA1);
      chk("direct sfr we", sfr_seen, 1'b1);
      acc(1'b1, SPC_INDIRECT, 16'h0090, 8'hB2);
      chk("indirect sfr we", sfr_seen, 1'b0);
      acc(1'b0, SPC_DIRECT, 16'h0090, 8'h00);
      chk("direct rd", rd, 8'hA1);
      chk("sfr sel", sel_seen, 1'b1);
      acc(1'b0, SPC_INDIRECT, 16'h0090, 8'h00);
      chk("upper ram rd", rd, 8'hB2);
      chk("ram sel", sel_seen, 1'b0);
      idle();
   endtask

   task automatic t_bank;
      for (int b = 0; b < 4; b++) begin
         acc(1'b1, SPC_DIRECT, {8'h00, PSW_ADDR}, 8'(b << PSW_BANK_LSB));
         acc(1'b1, SPC_GPREG, 16'h0002, 8'(8'hC0 + b));
         chk("bank sel", bank, b[1:0]);
      end
      for (int b = 0; b < 4; b++) begin
         acc(1'b0, SPC_INDIRECT, 16'(8 * b + 2), 8'h00);
         chk("bank reg", rd, 8'(8'hC0 + b));
      end
      acc(1'b1, SPC_GPREG, 16'h0000, 8'h40);
      acc(1'b1, SPC_GPREG, 16'h0001, 8'hA0);
      acc(1'b1, SPC_GPIND, 16'h0000, 8'h77);
      acc(1'b1, SPC_GPIND, 16'h0001, 8'h88);
      acc(1'b0, SPC_INDIRECT, 16'h0040, 8'h00);
      chk("via reg0", rd, 8'h77);
      acc(1'b0, SPC_INDIRECT, 16'h00A0, 8'h00);
      chk("via reg1", rd, 8'h88);
      acc(1'b1, SPC_DIRECT, {8'h00, PSW_ADDR}, 8'h00);
      idle();
   endtask

   task automatic t_bits;
      acc(1'b1, SPC_DIRECT, 16'h0022, 8'h00);
      acc(1'b1, SPC_DIRECT, 16'h002F, 8'h00);
      acc(1'b1, SPC_BIT, 16'h0013, 8'h01);
      acc(1'b1, SPC_BIT, 16'h007F, 8'h01);
      acc(1'b0, SPC_DIRECT, 16'h0022, 8'h00);
      chk("bit 0x13 byte", rd, 8'h08);
      acc(1'b0, SPC_DIRECT, 16'h002F, 8'h00);
      chk("bit 0x7f byte", rd, 8'h80);
      acc(1'b0, SPC_BIT, 16'h0013, 8'h00);
      chk("bit rd set", rd[0], 1'b1);
      acc(1'b0, SPC_BIT, 16'h0012, 8'h00);
      chk("bit rd clear", rd[0], 1'b0);
      idle();
   endtask

   task automatic t_onchip_external_ram;
      acc(1'b1, SPC_XDATA16, 16'h1234, 8'h6B);
      chk("no flash we", fl_seen, 1'b0);
      acc(1'b0, SPC_XDATA16, 16'hFF34, 8'h00);
      chk("mirror high", rd, 8'h6B);
      acc(1'b1, SPC_GPREG, 16'h0001, 8'h34);
      acc(1'b0, SPC_XDATA8, 16'h0001, 8'h00);
      chk("onchip_external_ram 8 bit", rd, 8'h6B);
      fsel_i = 1'b1;
      acc(1'b1, SPC_XDATA16, 16'h5634, 8'h99);
      chk("flash we", fl_seen, 1'b1);
      chk("flash addr", fa_seen, 16'h5634);
      chk("flash data", fw_seen, 8'h99);
      fsel_i = 1'b0;
      acc(1'b0, SPC_XDATA16, 16'h0034, 8'h00);
      chk("onchip_external_ram kept", rd, 8'h6B);
      idle();
   endtask

   task automatic t_uid;
      uid_i = 1'b1;
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, SPC_INDIRECT, 16'({8'h00, UID_BASE} + i), 8'h00);
         chk("uid internal", rd, UID_VALUE[8 * i +: 8]);
      end
      uid_i = 1'b0;
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, SPC_XDATA16, 16'({8'hA5, UID_BASE} + i), 8'h00);
         chk("uid external", rd, UID_VALUE[8 * i +: 8]);
      end
      idle();
   endtask

   task automatic t_warm;
      acc(1'b1, SPC_INDIRECT, 16'h00C8, 8'h2E);
      idle();
      do_reset(1'b0, 1'b0);
      do_reset(1'b0, 1'b1);
      acc(1'b0, SPC_INDIRECT, 16'h00C8, 8'h00);
      chk("ram kept", rd, 8'h2E);
      acc(1'b0, SPC_XDATA16, 16'h0034, 8'h00);
      chk("onchip_external_ram kept reset", rd, 8'h6B);
      idle();
   endtask

   initial begin
      do_reset(1'b1, 1'b0);
      t_stack();
      t_space();
      t_bank();
      t_bits();
      t_onchip_external_ram();
      t_uid();
      t_warm();
      close_out();
   end

   initial begin
      #100000;
      failures++;
      close_out();
   end
endmodule
